// >>> src/reclose_pkg.sv
/*
 * Shared constants, types and helper functions for the trip-initiated
 * reclose sequencer. Assumes a 10 MHz system clock and 5 ms timer steps.
 */
package reclose_pkg;

	localparam int CLK_PERIOD_NS = 100;
	localparam int TICK_PERIOD_NS = 5000000;
	localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int SETTING_MAX_MS = 1800000;
	localparam int TICK_MS = 5;
	localparam int SETTING_MAX_TICKS = SETTING_MAX_MS / TICK_MS;

	localparam int NUM_REQ = 5;
	localparam int NUM_SHOT = 5;
	localparam int TIME_W = 19;
	localparam int ADDR_W = 9;
	localparam int DATA_W = 32;
	localparam int SET_DEPTH = 100;

	localparam logic [TIME_W-1:0] TIME_MAX = TIME_W'(SETTING_MAX_TICKS);

	// Setting space: addr[8]=0, addr[7:6] kind, addr[5:3] request, addr[2:0] shot
	localparam int ADDR_SPACE_BIT = 8;
	localparam int ADDR_KIND_HI = 7;
	localparam int ADDR_KIND_LO = 6;
	localparam int ADDR_REQ_HI = 5;
	localparam int ADDR_REQ_LO = 3;
	localparam int ADDR_SHOT_HI = 2;
	localparam int ADDR_SHOT_LO = 0;

	localparam logic [1:0] KIND_START = 2'h0;
	localparam logic [1:0] KIND_DEAD = 2'h1;
	localparam logic [1:0] KIND_ACTION = 2'h2;
	localparam logic [1:0] KIND_RECLAIM = 2'h3;

	localparam logic [ADDR_W-1:0] ADDR_SHOT_EN = 9'h100;
	localparam logic [ADDR_W-1:0] ADDR_FUNC_RECLAIM = 9'h101;
	localparam logic [ADDR_W-1:0] ADDR_CONFIG = 9'h102;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 9'h103;
	localparam logic [ADDR_W-1:0] ADDR_COMMAND = 9'h104;

	localparam int CFG_LOCK_ON_RETURN_BIT = 0;
	localparam int CMD_OP_RESET_BIT = 0;

	localparam logic [NUM_REQ*NUM_SHOT-1:0] SHOT_EN_RST = 25'h0000000;
	localparam logic [TIME_W-1:0] TIME_RST = 19'h00000;
	localparam logic CFG_LOCK_RST = 1'h1;

	typedef enum logic [2:0] {
		ST_READY = 3'h0,
		ST_WAIT_OPEN = 3'h1,
		ST_DEAD = 3'h2,
		ST_CLOSE = 3'h3,
		ST_RECLAIM = 3'h4,
		ST_FUNC_RECLAIM = 3'h5,
		ST_FINAL = 3'h6,
		ST_LOCKOUT = 3'h7
	} seq_state_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic closed;
		logic open;
		logic fail_ack;
	} breaker_stat_t;

	typedef struct packed {
		logic reclose_active_flag;
		logic [NUM_REQ-1:0] request_pending_flag;
		logic [NUM_SHOT-1:0] shot_running_flag;
		logic close_request;
		logic final_trip;
		logic reclose_blocked_state;
		logic function_recovery_timer;
		logic ready;
	} seq_status_t;

	localparam seq_status_t STATUS_RST = '{default: 1'b0, ready: 1'b1};

	function automatic logic [6:0] set_index(input logic [1:0] kind, input logic [2:0] req,
		input logic [2:0] shot);
		logic [6:0] k;
		logic [6:0] r;
		logic [6:0] s;
		k = {5'h00, kind};
		r = {4'h0, req};
		s = {4'h0, shot};
		return 7'(k * 7'h19 + r * 7'h05 + s);
	endfunction : set_index

	// Returns {found, index} of the lowest enabled shot at or above start
	function automatic logic [3:0] next_shot(input logic [NUM_SHOT-1:0] en,
		input logic [2:0] start);
		logic [3:0] res;
		res = 4'h0;
		for (int i = NUM_SHOT - 1; i >= 0; i--) begin
			if (en[i] && (3'(i) >= start)) begin
				res = {1'b1, 3'(i)};
			end
		end
		return res;
	endfunction : next_shot

	// Settings above the range saturate rather than wrap
	function automatic logic [TIME_W-1:0] sat_time(input logic [DATA_W-1:0] d);
		logic [DATA_W-1:0] lim;
		lim = DATA_W'(SETTING_MAX_TICKS);
		return (d > lim) ? TIME_MAX : d[TIME_W-1:0];
	endfunction : sat_time

endpackage : reclose_pkg

// >>> src/tick_gen.sv
/*
 * Timebase divider: one-cycle tick every TICK_CYCLES enabled clocks.
 * Assumes a synchronous restart pulse aligns it to timer starts.
 */
`timescale 1ns/1ns
module tick_gen #(
	parameter int TICK_CYCLES = 50000
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic restart,
	output logic tick
);
	localparam int CW = $clog2(TICK_CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

	logic [CW-1:0] cnt_r;

	assign tick = clk_en && !restart && (cnt_r == LAST);

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_r <= '0;
		end else if (clk_en) begin
			if (restart || cnt_r == LAST) begin
				cnt_r <= '0;
			end else begin
				cnt_r <= cnt_r + 1'b1;
			end
		end
	end
endmodule : tick_gen

// >>> src/trip_initiated_reclose_sequencer.sv
/*
 * Trip-initiated reclose sequencer: per-shot dead and reclaim timing,
 * close requests to the breaker object, final trip and lock-out.
 * Assumes request and breaker inputs are synchronous to sys_clk and that
 * the breaker object drops its close command itself on the closed state.
 */
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/1ns
// What this block does
// - Trip start: no start delay, watch trip
// - Timers programmable in 5 ms steps
// - Only enabled shots, ascending order
// - First trip raises running, requested, shot flags
// - Dead timer after open and trip release
// - Dead expiry issues close request unconditionally
// - Closed indication starts shot reclaim timer
// - Trip during reclaim advances shot
// - Later shot runs its own dead time
// - No shot left: final trip, lock-out
// - Lock-out until operator reset, then closed
// - Reclaim expiry clears flags, starts function reclaim
// - Return in function reclaim: configurable lock-out
// - Zero timers are skipped immediately
// - Function reclaim expiry returns to ready
// - Five requests, first highest priority
// - Critical request halts sequence at once
// - Breaker failure acknowledgement forces lock-out
module trip_initiated_reclose_sequencer #(
	parameter int TICK_CYCLES = reclose_pkg::TICK_CYCLES
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire reclose_pkg::reg_req_t reg_req,
	output logic [reclose_pkg::DATA_W-1:0] reg_rdata,
	input wire logic [reclose_pkg::NUM_REQ-1:0] request_in,
	input wire logic critical_request,
	input wire reclose_pkg::breaker_stat_t controlled_breaker_object,
	input wire logic operator_reset,
	output reclose_pkg::seq_status_t seq_status
);
	localparam int SET_W = reclose_pkg::TIME_W;

	reclose_pkg::seq_state_t state_r, state_nxt;
	logic [2:0] cur_req_r, cur_req_nxt;
	logic [2:0] cur_shot_r, cur_shot_nxt;
	logic [SET_W-1:0] set_mem [0:reclose_pkg::SET_DEPTH-1];
	logic [reclose_pkg::NUM_REQ*reclose_pkg::NUM_SHOT-1:0] shot_en_r;
	logic [SET_W-1:0] func_reclaim_r;
	logic lock_on_return_r;
	logic op_reset_pend_r;
	logic [reclose_pkg::NUM_REQ-1:0] req_prev_r;
	logic [reclose_pkg::NUM_REQ-1:0] req_rise;
	logic [SET_W-1:0] timer_r;
	logic [SET_W-1:0] timer_limit;
	logic timer_done;
	logic tick;
	logic restart;
	logic cand_valid;
	logic [2:0] cand_req;
	logic [2:0] cand_shot;
	logic [3:0] adv;
	logic [reclose_pkg::NUM_SHOT-1:0] cur_en;
	logic cur_rise;
	logic cmd_reset;
	logic [2:0] a_req;
	logic [2:0] a_shot;
	logic a_set_ok;
	reclose_pkg::seq_status_t status_nxt;

	assign a_req = reg_req.addr[reclose_pkg::ADDR_REQ_HI:reclose_pkg::ADDR_REQ_LO];
	assign a_shot = reg_req.addr[reclose_pkg::ADDR_SHOT_HI:reclose_pkg::ADDR_SHOT_LO];
	assign a_set_ok = !reg_req.addr[reclose_pkg::ADDR_SPACE_BIT]
		&& (a_req < 3'(reclose_pkg::NUM_REQ)) && (a_shot < 3'(reclose_pkg::NUM_SHOT));
	assign cmd_reset = reg_req.wr && (reg_req.addr == reclose_pkg::ADDR_COMMAND)
		&& reg_req.wdata[reclose_pkg::CMD_OP_RESET_BIT];

	tick_gen #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_tick (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.restart(restart),
		.tick(tick)
	);

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < reclose_pkg::SET_DEPTH; i++) begin
				set_mem[i] <= reclose_pkg::TIME_RST;
			end
		end else if (clk_en && reg_req.wr && a_set_ok) begin
			set_mem[reclose_pkg::set_index(
				reg_req.addr[reclose_pkg::ADDR_KIND_HI:reclose_pkg::ADDR_KIND_LO],
				a_req, a_shot)] <= reclose_pkg::sat_time(reg_req.wdata);
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			shot_en_r <= reclose_pkg::SHOT_EN_RST;
			func_reclaim_r <= reclose_pkg::TIME_RST;
			lock_on_return_r <= reclose_pkg::CFG_LOCK_RST;
		end else if (clk_en && reg_req.wr) begin
			case (reg_req.addr)
				reclose_pkg::ADDR_SHOT_EN: begin
					shot_en_r <= reg_req.wdata[reclose_pkg::NUM_REQ*reclose_pkg::NUM_SHOT-1:0];
				end
				reclose_pkg::ADDR_FUNC_RECLAIM: begin
					func_reclaim_r <= reclose_pkg::sat_time(reg_req.wdata);
				end
				reclose_pkg::ADDR_CONFIG: begin
					lock_on_return_r <= reg_req.wdata[reclose_pkg::CFG_LOCK_ON_RETURN_BIT];
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata <= '0;
		end else if (clk_en) begin
			if (!reg_req.rd) begin
				reg_rdata <= '0;
			end else if (a_set_ok) begin
				reg_rdata <= reclose_pkg::DATA_W'(set_mem[reclose_pkg::set_index(
					reg_req.addr[reclose_pkg::ADDR_KIND_HI:reclose_pkg::ADDR_KIND_LO],
					a_req, a_shot)]);
			end else begin
				case (reg_req.addr)
					reclose_pkg::ADDR_SHOT_EN: reg_rdata <= reclose_pkg::DATA_W'(shot_en_r);
					reclose_pkg::ADDR_FUNC_RECLAIM: begin
						reg_rdata <= reclose_pkg::DATA_W'(func_reclaim_r);
					end
					reclose_pkg::ADDR_CONFIG: begin
						reg_rdata <= reclose_pkg::DATA_W'(lock_on_return_r);
					end
					reclose_pkg::ADDR_STATUS: begin
						reg_rdata <= reclose_pkg::DATA_W'({op_reset_pend_r, state_r, seq_status});
					end
					default: reg_rdata <= '0;
				endcase
			end
		end
	end

	assign req_rise = request_in & ~req_prev_r;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			req_prev_r <= '0;
		end else if (clk_en) begin
			req_prev_r <= request_in;
		end
	end

	// reset is remembered until the breaker closes
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			op_reset_pend_r <= 1'b0;
		end else if (clk_en) begin
			if (state_r != reclose_pkg::ST_LOCKOUT) begin
				op_reset_pend_r <= 1'b0;
			end else if (operator_reset || cmd_reset) begin
				op_reset_pend_r <= 1'b1;
			end
		end
	end

	// lowest index wins; needs an enabled shot
	always_comb begin
		cand_valid = 1'b0;
		cand_req = 3'h0;
		cand_shot = 3'h0;
		for (int r = reclose_pkg::NUM_REQ - 1; r >= 0; r--) begin
			logic [3:0] f;
			f = reclose_pkg::next_shot(shot_en_r[r*reclose_pkg::NUM_SHOT +: reclose_pkg::NUM_SHOT],
				3'h0);
			if (req_rise[r] && f[3]) begin
				cand_valid = 1'b1;
				cand_req = 3'(r);
				cand_shot = f[2:0];
			end
		end
	end

	assign cur_en = shot_en_r[cur_req_r*reclose_pkg::NUM_SHOT +: reclose_pkg::NUM_SHOT];
	assign cur_rise = req_rise[cur_req_r];
	assign adv = reclose_pkg::next_shot(cur_en, 3'(cur_shot_r + 3'h1));

	always_comb begin
		case (state_r)
			reclose_pkg::ST_DEAD: begin
				timer_limit = set_mem[reclose_pkg::set_index(reclose_pkg::KIND_DEAD,
					cur_req_r, cur_shot_r)];
			end
			reclose_pkg::ST_RECLAIM: begin
				timer_limit = set_mem[reclose_pkg::set_index(reclose_pkg::KIND_RECLAIM,
					cur_req_r, cur_shot_r)];
			end
			reclose_pkg::ST_FUNC_RECLAIM: timer_limit = func_reclaim_r;
			default: timer_limit = reclose_pkg::TIME_RST;
		endcase
	end

	// zero limit expires on the first cycle
	assign timer_done = (timer_r >= timer_limit);
	assign restart = (state_nxt != state_r);

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			timer_r <= reclose_pkg::TIME_RST;
		end else if (clk_en) begin
			if (restart) begin
				timer_r <= reclose_pkg::TIME_RST;
			end else if (tick && !timer_done) begin
				timer_r <= timer_r + 1'b1;
			end
		end
	end

	always_comb begin
		state_nxt = state_r;
		cur_req_nxt = cur_req_r;
		cur_shot_nxt = cur_shot_r;
		case (state_r)
			reclose_pkg::ST_READY: begin
				// trip edge starts the shot directly
				if (cand_valid) begin
					state_nxt = reclose_pkg::ST_WAIT_OPEN;
					cur_req_nxt = cand_req;
					cur_shot_nxt = cand_shot;
				end
			end
			reclose_pkg::ST_WAIT_OPEN: begin
				if (controlled_breaker_object.open && !request_in[cur_req_r]) begin
					state_nxt = reclose_pkg::ST_DEAD;
				end
			end
			reclose_pkg::ST_DEAD: begin
				// close after this shot's dead time
				if (timer_done) begin
					state_nxt = reclose_pkg::ST_CLOSE;
				end
			end
			reclose_pkg::ST_CLOSE: begin
				if (controlled_breaker_object.closed) begin
					state_nxt = reclose_pkg::ST_RECLAIM;
				end
			end
			reclose_pkg::ST_RECLAIM: begin
				if (cur_rise) begin
					if (adv[3]) begin
						state_nxt = reclose_pkg::ST_WAIT_OPEN;
						cur_shot_nxt = adv[2:0];
					end else begin
						state_nxt = reclose_pkg::ST_FINAL;
					end
				end else if (timer_done) begin
					state_nxt = reclose_pkg::ST_FUNC_RECLAIM;
				end
			end
			reclose_pkg::ST_FUNC_RECLAIM: begin
				// return either locks out or restarts
				if (cand_valid && lock_on_return_r) begin
					state_nxt = reclose_pkg::ST_FINAL;
				end else if (cand_valid) begin
					state_nxt = reclose_pkg::ST_WAIT_OPEN;
					cur_req_nxt = cand_req;
					cur_shot_nxt = cand_shot;
				end else if (timer_done) begin
					state_nxt = reclose_pkg::ST_READY;
				end
			end
			reclose_pkg::ST_FINAL: state_nxt = reclose_pkg::ST_LOCKOUT;
			reclose_pkg::ST_LOCKOUT: begin
				// leave only after reset then closed
				if (op_reset_pend_r && controlled_breaker_object.closed) begin
					state_nxt = reclose_pkg::ST_READY;
				end
			end
			default: state_nxt = reclose_pkg::ST_READY;
		endcase
		// halt all; a held halt still reaches lock-out
		if ((critical_request || controlled_breaker_object.fail_ack)
			&& state_r != reclose_pkg::ST_LOCKOUT && state_r != reclose_pkg::ST_FINAL) begin
			state_nxt = reclose_pkg::ST_FINAL;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_r <= reclose_pkg::ST_READY;
			cur_req_r <= 3'h0;
			cur_shot_r <= 3'h0;
		end else if (clk_en) begin
			state_r <= state_nxt;
			cur_req_r <= cur_req_nxt;
			cur_shot_r <= cur_shot_nxt;
		end
	end

	always_comb begin
		logic act;
		act = (state_nxt == reclose_pkg::ST_WAIT_OPEN) || (state_nxt == reclose_pkg::ST_DEAD)
			|| (state_nxt == reclose_pkg::ST_CLOSE) || (state_nxt == reclose_pkg::ST_RECLAIM);
		status_nxt = reclose_pkg::STATUS_RST;
		status_nxt.ready = (state_nxt == reclose_pkg::ST_READY);
		status_nxt.reclose_active_flag = act;
		status_nxt.request_pending_flag = act ? 5'(5'h01 << cur_req_nxt) : 5'h00;
		status_nxt.shot_running_flag = act ? 5'(5'h01 << cur_shot_nxt) : 5'h00;
		status_nxt.close_request = (state_nxt == reclose_pkg::ST_CLOSE);
		status_nxt.final_trip = (state_nxt == reclose_pkg::ST_FINAL);
		status_nxt.reclose_blocked_state = (state_nxt == reclose_pkg::ST_LOCKOUT);
		status_nxt.function_recovery_timer = (state_nxt == reclose_pkg::ST_FUNC_RECLAIM);
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			seq_status <= reclose_pkg::STATUS_RST;
		end else if (clk_en) begin
			seq_status <= status_nxt;
		end
	end
endmodule : trip_initiated_reclose_sequencer

// >>> tb/reclose_monitor.sv
/* Port checker for the reclose sequencer.
   Bound to every sequencer instance; one clock, asynchronous reset. */
`timescale 1ns/1ns
module reclose_monitor #(
	parameter int TICK_CYCLES = 4
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire reclose_pkg::reg_req_t reg_req,
	input wire logic [reclose_pkg::DATA_W-1:0] reg_rdata,
	input wire logic [reclose_pkg::NUM_REQ-1:0] request_in,
	input wire logic critical_request,
	input wire reclose_pkg::breaker_stat_t controlled_breaker_object,
	input wire logic operator_reset,
	input wire reclose_pkg::seq_status_t seq_status
);
	wire logic act = seq_status.reclose_active_flag;
	wire logic blk = seq_status.reclose_blocked_state;
	wire logic cls = seq_status.close_request;
	wire logic idle = !act && seq_status.request_pending_flag == '0
		&& seq_status.shot_running_flag == '0;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst || !clk_en);

	AST_RD_IDLE: assert property ($past(clk_en) && !$past(reg_req.rd) |-> reg_rdata == '0)
		else $error("read data not idle");
	AST_SHOT_ONEHOT: assert property ($onehot0(seq_status.shot_running_flag))
		else $error("more than one shot running");
	AST_FIRST_TRIP: assert property ($rose(act) |-> |$past(request_in) && !idle)
		else $error("running without request flags");
	AST_CLOSE_ACTIVE: assert property (cls |-> act)
		else $error("close request outside a cycle");
	AST_CLOSE_DROP: assert property (cls && controlled_breaker_object.closed
		|-> ##[1:2] !cls) else $error("close request kept after closed");
	AST_FINAL_DROP: assert property (seq_status.final_trip |=> blk && idle)
		else $error("final trip not followed by lock-out");
	AST_CRIT_HALT: assert property (critical_request && !blk |-> ##[1:3] blk)
		else $error("critical request did not halt");
	AST_FAIL_LOCK: assert property (controlled_breaker_object.fail_ack |-> ##[1:3] blk)
		else $error("failure ack did not lock out");
	AST_LOCK_EXIT: assert property ($fell(blk) |-> seq_status.ready
		&& controlled_breaker_object.closed) else $error("lock-out left wrongly");
	AST_FUNC_CLEAR: assert property (seq_status.function_recovery_timer |-> idle)
		else $error("flags set in function reclaim");
endmodule : reclose_monitor

bind trip_initiated_reclose_sequencer reclose_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (
	.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en), .reg_req(reg_req),
	.reg_rdata(reg_rdata), .request_in(request_in), .critical_request(critical_request),
	.controlled_breaker_object(controlled_breaker_object), .operator_reset(operator_reset),
	.seq_status(seq_status)
);

// >>> tb/breaker_model.sv
/* Behavioural breaker object behind the sequencer.
   Assumes the bench commands opening; closes on request, fast or slow. */
`timescale 1ns/1ns
module breaker_model (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic close_request,
	input wire logic open_cmd,
	input wire logic close_cmd,
	input wire logic fail,
	input wire logic slow,
	output reclose_pkg::breaker_stat_t stat
);
	logic [2:0] dly_r;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			stat <= '{closed: 1'b1, open: 1'b0, fail_ack: 1'b0};
			dly_r <= 3'h0;
		end else begin
			stat.fail_ack <= fail;
			dly_r <= 3'h0;
			if (open_cmd) begin
				stat.closed <= 1'b0;
				stat.open <= 1'b1;
			end else if (stat.open && (close_request || close_cmd)) begin
				dly_r <= dly_r + 3'h1;
				if (dly_r == (slow ? 3'h5 : 3'h1)) begin
					stat.closed <= 1'b1;
					stat.open <= 1'b0;
				end
			end
		end
	end
endmodule : breaker_model

// >>> tb/tb_trip_initiated_reclose_sequencer.sv
/* Self-checking bench for the reclose sequencer and its breaker model.
   Assumes a shortened timebase of TC clocks per 5 ms tick. */
`timescale 1ns/1ns
module tb_trip_initiated_reclose_sequencer;
	localparam int TC = 4;
	logic sys_clk;
	logic sys_rst;
	reclose_pkg::reg_req_t reg_req;
	logic [31:0] reg_rdata;
	logic [4:0] request_in;
	logic critical_request, operator_reset;
	logic open_cmd, close_cmd, fail, slow;
	logic clk_en;
	logic rd_seen = 1'b0;
	logic [31:0] rv;
	logic [31:0] rd_q[$];
	reclose_pkg::breaker_stat_t brk;
	reclose_pkg::seq_status_t st, snap;
	int fail_count = 0;
	int n_checks = 0;
	int seed, cnt;

	trip_initiated_reclose_sequencer #(.TICK_CYCLES(TC)) uut (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en), .reg_req(reg_req),
		.reg_rdata(reg_rdata), .request_in(request_in), .critical_request(critical_request),
		.controlled_breaker_object(brk), .operator_reset(operator_reset), .seq_status(st)
	);
	breaker_model u_brk (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .close_request(st.close_request),
		.open_cmd(open_cmd), .close_cmd(close_cmd), .fail(fail), .slow(slow), .stat(brk)
	);

	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	task automatic chk(input logic ok, input string msg);
		n_checks++;
		if (ok !== 1'b1) begin
			fail_count++;
			$display("ERROR %0t %s", $time, msg);
		end
	endtask : chk

	task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t read %h expected %h", $time, got, exp);
		end
	endtask : chk_rd

	// Read data lives only in the cycle after the strobe
	always @(posedge sys_clk) begin
		if (rd_seen)
			chk_rd(reg_rdata, rd_q.pop_front());
		rd_seen <= reg_req.rd;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : cyc

	task automatic wr(input logic [8:0] a, input logic [31:0] d);
		reg_req <= '{1'b1, 1'b0, a, d};
		cyc(1);
		reg_req <= '0;
		cyc(1);
	endtask : wr

	task automatic rd(input logic [8:0] a, input logic [31:0] e);
		rd_q.push_back(e);
		reg_req <= '{1'b0, 1'b1, a, 32'h0};
		cyc(1);
		reg_req <= '0;
		cyc(1);
	endtask : rd

	// Trip, snapshot the answer, breaker opens, trip releases
	task automatic trip(input logic [4:0] m);
		request_in <= m;
		cyc(1);
		@(negedge sys_clk) snap = st;
		@(posedge sys_clk) open_cmd <= 1'b1;
		cyc(1);
		open_cmd <= 1'b0;
		cyc(1);
		request_in <= '0;
	endtask : trip

	task automatic wait_st(input int b, input logic v, input int lim);
		cnt = 0;
		do begin
			@(negedge sys_clk);
			cnt++;
		end while (st[b] !== v && cnt < lim);
		chk(st[b] === v, "status wait ran out");
		@(posedge sys_clk);
	endtask : wait_st

	task automatic unlock(input logic by_cmd);
		if (by_cmd) begin
			wr(9'h104, 32'h1);
		end else begin
			operator_reset <= 1'b1;
			cyc(1);
			operator_reset <= 1'b0;
		end
		close_cmd <= 1'b1;
		cyc(8);
		close_cmd <= 1'b0;
		wait_st(0, 1'b1, 20);
	endtask : unlock

	task automatic succeed;
		trip(5'h02);
		wait_st(4, 1'b1, 60);
		wait_st(1, 1'b1, 60);
	endtask : succeed

	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : finish_test

	// Whole run is under a thousand cycles; twenty times that means a hang
	initial begin
		cyc(20000);
		fail_count++;
		finish_test();
	end

	initial begin
		seed = 78539;
		reg_req = '0;
		request_in = '0;
		critical_request = 1'b0;
		operator_reset = 1'b0;
		open_cmd = 1'b0;
		close_cmd = 1'b0;
		fail = 1'b0;
		slow = 1'b0;
		clk_en = 1'b1;
		sys_rst = 1'b1;
		cyc(6);
		sys_rst <= 1'b0;
		cyc(1);
		rd(9'h102, 32'h1);
		rd(9'h048, 32'h0);
		rd(9'h1FF, 32'h0);
		rd(9'h103, 32'h1);
		rv = $random(seed) & 32'h3FFFF;
		wr(9'h050, rv);
		rd(9'h050, rv);
		// Write while frozen must not land
		clk_en <= 1'b0;
		wr(9'h050, 32'h0);
		clk_en <= 1'b1;
		rd(9'h050, rv);
		wr(9'h010, 32'hFFFFFFFF);
		rd(9'h010, 32'h57E40);
		wr(9'h068, 32'h7);
		rd(9'h068, 32'h0);
		$display("test registers done");
		wr(9'h100, 32'h60);
		wr(9'h048, 32'h2);
		wr(9'h049, 32'h5);
		wr(9'h0C8, 32'h28);
		wr(9'h0C9, 32'h28);
		wr(9'h101, 32'h4);
		trip(5'h02);
		chk(snap[15:5] === 11'h441, "first trip flags");
		wait_st(4, 1'b1, 60);
		chk(cnt >= 2 * TC && cnt <= 2 * TC + 4, "first dead time");
		wait_st(4, 1'b0, 20);
		trip(5'h02);
		chk(snap.shot_running_flag === 5'h02 && snap[15] === 1'b1, "next shot");
		slow <= 1'b1;
		wait_st(4, 1'b1, 60);
		chk(cnt >= 5 * TC && cnt <= 5 * TC + 4, "second dead time");
		wait_st(4, 1'b0, 30);
		trip(5'h02);
		chk(snap.final_trip === 1'b1 && snap[15:5] === 11'h0, "final trip");
		chk(st.reclose_blocked_state === 1'b1, "lock-out");
		trip(5'h02);
		chk(snap[15] === 1'b0 && snap.reclose_blocked_state === 1'b1, "refused");
		close_cmd <= 1'b1;
		cyc(8);
		close_cmd <= 1'b0;
		open_cmd <= 1'b1;
		cyc(1);
		open_cmd <= 1'b0;
		chk(st.reclose_blocked_state === 1'b1, "left without reset");
		unlock(1'b0);
		$display("test both shots fail done");
		wr(9'h0C8, 32'h3);
		slow <= 1'b0;
		succeed();
		chk(st[15:5] === 11'h0, "flags after reclaim");
		wait_st(0, 1'b1, 60);
		succeed();
		trip(5'h02);
		chk(snap.final_trip === 1'b1, "return in reclaim");
		unlock(1'b0);
		wr(9'h102, 32'h0);
		succeed();
		trip(5'h02);
		chk(snap[15] === 1'b1 && snap.final_trip === 1'b0, "restart on return");
		critical_request <= 1'b1;
		wait_st(2, 1'b1, 6);
		critical_request <= 1'b0;
		unlock(1'b1);
		$display("test reclaim and halt done");
		wr(9'h100, 32'h61);
		wr(9'h101, 32'h0);
		trip(5'h03);
		chk(snap.request_pending_flag === 5'h01, "priority");
		wait_st(4, 1'b1, 4);
		wait_st(0, 1'b1, 12);
		trip(5'h02);
		fail <= 1'b1;
		wait_st(2, 1'b1, 6);
		fail <= 1'b0;
		unlock(1'b0);
		$display("test zero timers and failure done");
		finish_test();
	end
endmodule : tb_trip_initiated_reclose_sequencer
